// [bench/pfs_board.sv]
// Purpose: Board-side model that drives every shared pin the block releases.
// Assumes: Vectors are packed as {serial[3:0], flag[7:0], data[7:0], addr[13:0]}.
// Notes: The board drives each pin the block leaves undriven, so no pin ever floats.
`timescale 1ns/100ps
`default_nettype none

module pfs_board (
	input wire logic [33:0] blk_out_in,
	input wire logic [33:0] blk_oe_in,
	input wire logic [33:0] drv_in,
	output logic [33:0] lvl_out
);
	// Wire level: where the block drives, its own level wins
	// Board level elsewhere, so a pin is never left unknown
	assign lvl_out = (blk_oe_in & blk_out_in) | (~blk_oe_in & drv_in);
endmodule // pfs_board

`default_nettype wire

// [bench/pin_function_select_tb.sv]
// Purpose: Self-checking bench for the pin function select block.
// Assumes: The board model supplies the pin levels; no random stimulus is used.
// Notes: Table rows cover the serial pin modes; straps and resets are tested by hand.
`timescale 1ns/100ps
`default_nettype none
`include "pfs_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module pin_function_select_tb;
	typedef struct packed {logic [31:0] ctrl; logic [3:0] ser; logic [3:0] pf_hi;} pfs_row_t;
	logic clk, rst_n, rd, wr, wreq, core_doe, host_ack_n, tx_dat, ser_on, hado;
	logic [4:0] adr;
	logic [31:0] wdat, rdat, got;
	logic [33:0] lvl;
	logic [13:0] a_o, a_oe, a_drv, core_adr;
	logic [7:0] d_o, d_oe, d_drv, pf_o, pf_oe, pf_drv, core_din, core_dout;
	logic [3:0] s_o, s_oe, s_drv, be;
	logic [15:0] host_ad, hadi;
	logic hcs_n, hal, hrd_n, hwr_n, ie_n, il0_n, il1_n, i2_n, txs, rxs, rxd, i1_n, i0_n, fin;
	int errors = 0;
	int n_tests = 0;
	// Last row clears the serial bit, so the later reset must restore it
	pfs_row_t rows [4] = '{'{32'h0000_0400, 4'hA, 4'hA}, '{32'h0, 4'h6, 4'h5},
		'{32'h0000_0400, 4'h4, 4'hF}, '{32'h0, 4'h8, 4'h0}};

	// Board model drives the pins the block releases
	pfs_board board (.blk_out_in({s_o, pf_o, d_o, a_o}), .blk_oe_in({s_oe, pf_oe, d_oe, a_oe}),
		.drv_in({s_drv, pf_drv, d_drv, a_drv}), .lvl_out(lvl));

	pfs_top dut (.core_clk_in(clk), .resetn_in(rst_n), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
		.avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
		.addr_pin_in(lvl[13:1]), .addr_pin_out(a_o), .addr_pin_oe_out(a_oe),
		.data_pin_in(lvl[21:14]), .data_pin_out(d_o), .data_pin_oe_out(d_oe),
		.programmable_flag_in(lvl[29:22]), .programmable_flag_out(pf_o),
		.programmable_flag_oe_out(pf_oe), .serial_one_pin_in(lvl[33:30]),
		.serial_one_pin_out(s_o), .serial_one_pin_oe_out(s_oe), .core_addr_in(core_adr),
		.core_data_in(core_din), .core_data_oe_in(core_doe), .core_data_out(core_dout),
		.host_addr_data_in(hadi), .host_addr_data_oe_in(hado),
		.host_acknowledge_n_in(host_ack_n), .host_addr_data_out(host_ad),
		.host_chip_select_n_out(hcs_n), .host_address_latch_out(hal),
		.host_read_strobe_n_out(hrd_n), .host_write_strobe_n_out(hwr_n),
		.edge_interrupt_n_out(ie_n), .level_interrupt_zero_n_out(il0_n),
		.level_interrupt_one_n_out(il1_n), .interrupt_two_n_out(i2_n),
		.serial_one_tx_data_in(tx_dat), .serial_one_tx_sync_in(1'b0),
		.serial_one_tx_sync_oe_in(1'b0), .serial_one_rx_sync_in(1'b0),
		.serial_one_rx_sync_oe_in(1'b0), .serial_one_tx_sync_out(txs),
		.serial_one_rx_sync_out(rxs), .serial_one_rx_data_out(rxd),
		.interrupt_one_n_out(i1_n), .interrupt_zero_n_out(i0_n), .flag_input_out(fin));

	// Free-running 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// One bus access; holds the request until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			k++;
		end while (wreq !== 1'b0 && k < 50);
		got = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		// A slave that never answers ends the run
		if (k >= 50) begin
			errors++;
			tally_and_finish();
		end
	endtask

	// Pins need the synchroniser plus one register edge to show
	task automatic settle;
		repeat (10) @(posedge clk);
	endtask

	// Long reset with the strap pins already steady
	task automatic do_reset(input logic [7:0] pf);
		@(posedge clk);
		pf_drv <= pf;
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Watchdog, far beyond the roughly 190 cycles the tests take
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		rst_n = 1'b0; rd = 1'b0; wr = 1'b0; adr = 5'h00; wdat = 32'h0;
		a_drv = 14'h2AAA; d_drv = 8'hE5; pf_drv = 8'h00; s_drv = 4'h0;
		core_adr = 14'h0000; core_din = 8'h3C; core_doe = 1'b0; host_ack_n = 1'b1; tx_dat = 1'b0;
		be = 4'hF; hadi = 16'hBEEF; hado = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		bus(1'b0, `PFS_OFS_SYS_CTRL, 32'h0);
		`CHK(got, 32'h0000_0400)
		bus(1'b0, `PFS_OFS_STATUS, 32'h0);
		`CHK(got[4:0], 5'h10)
		bus(1'b0, 5'h14, 32'h0);
		`CHK(got, 32'h0)
		// Plain bus mode: address and data pins keep their bus functions
		core_adr <= 14'h1555;
		settle();
		`CHK({a_oe, a_o}, {14'h3FFF, 14'h1555})
		`CHK({core_dout, hcs_n}, {d_drv, 1'b1})
		core_doe <= 1'b1;
		settle();
		`CHK({d_oe, d_o}, {8'hFF, core_din})
		core_doe <= 1'b0;
		bus(1'b1, `PFS_OFS_FLAG_OUT, 32'h1);
		// Lane one masked: the serial select must not move
		be <= 4'h1;
		bus(1'b1, `PFS_OFS_SYS_CTRL, 32'h0);
		be <= 4'hF;
		bus(1'b0, `PFS_OFS_SYS_CTRL, 32'h0);
		`CHK(got, 32'h0000_0400)
		$display("plain mode done");
		// Serial pin functions against interrupt and flag functions
		foreach (rows[i]) begin
			bus(1'b1, `PFS_OFS_SYS_CTRL, rows[i].ctrl);
			s_drv <= rows[i].ser;
			pf_drv <= {rows[i].pf_hi, 4'h0};
			settle();
			ser_on = rows[i].ctrl[`PFS_SYS_SERIAL_BIT];
			`CHK({rxd, rxs, txs}, ser_on ? rows[i].ser[3:1] : 3'h0)
			`CHK({fin, i0_n, i1_n}, ser_on ? 3'h3 : rows[i].ser[3:1])
			`CHK(s_o[0], ser_on ? tx_dat : 1'b1)
			`CHK({i2_n, il1_n, il0_n, ie_n}, rows[i].pf_hi)
			bus(1'b0, `PFS_OFS_SYS_CTRL, 32'h0);
			`CHK(got[`PFS_SYS_SERIAL_BIT], ser_on)
			$display("row %0d done", i);
		end
		// Second reset with mode C strapped high selects the host port
		host_ack_n <= 1'b0;
		do_reset(8'h04);
		bus(1'b0, `PFS_OFS_STATUS, 32'h0);
		`CHK(got[4:0], 5'h14)
		bus(1'b0, `PFS_OFS_SYS_CTRL, 32'h0);
		`CHK(got, 32'h0000_0400)
		settle();
		`CHK(host_ad, {d_drv[2:0], a_drv[13:1]})
		`CHK({hwr_n, hrd_n, hal, hcs_n}, d_drv[7:4])
		`CHK({core_dout, d_o[3]}, {8'h00, 1'b0})
		// Flag pins move after capture; straps and host mode must hold
		pf_drv <= 8'hCB;
		settle();
		`CHK({i2_n, il1_n, il0_n, ie_n}, 4'hC)
		bus(1'b0, `PFS_OFS_STATUS, 32'h0);
		`CHK(got[4:0], 5'h14)
		`CHK(got[15:8], 8'hCB)
		`CHK(host_ad, {d_drv[2:0], a_drv[13:1]})
		// Drive the low flag pins from the block; straps must not follow
		bus(1'b1, `PFS_OFS_FLAG_VAL, 32'hA5);
		bus(1'b1, `PFS_OFS_FLAG_DIR, 32'h0F);
		settle();
		`CHK({pf_oe, pf_o}, {8'h0F, 8'hA5})
		`CHK({i2_n, il1_n, il0_n, ie_n}, 4'hC)
		bus(1'b0, `PFS_OFS_STATUS, 32'h0);
		`CHK({got[15:8], got[4:0]}, {8'hC5, 5'h14})
		// Host drives its address and data lines onto the shared pins
		hado <= 1'b1;
		settle();
		`CHK({a_oe, d_oe}, {14'h3FFF, 8'h0F})
		`CHK(host_ad, hadi)
		$display("host mode done");
		tally_and_finish();
	end
endmodule // pin_function_select_tb

`default_nettype wire

// [src/pfs_params.svh]
// Purpose: Offsets, field positions, reset values and counts for the pin function select block.
// Assumes: Byte addressing on the register bus, one 32-bit word per register.
// Notes: Included by its bare name; definitions only.
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH

// Register byte offsets
`define PFS_OFS_SYS_CTRL 5'h00
`define PFS_OFS_FLAG_DIR 5'h04
`define PFS_OFS_FLAG_VAL 5'h08
`define PFS_OFS_FLAG_OUT 5'h0C
`define PFS_OFS_STATUS 5'h10

// Field positions
`define PFS_SYS_SERIAL_BIT 10
`define PFS_STAT_DONE_BIT 4
`define PFS_STAT_PF_LSB 8
`define PFS_STAT_FLAG_IN_BIT 16
`define PFS_STRAP_MODE_C 2

// Reset values
`define PFS_RST_SERIAL 1'h1
`define PFS_RST_FLAG_DIR 8'h00
`define PFS_RST_FLAG_VAL 8'h00
`define PFS_RST_FLAG_OUT 1'h0

// Synchronised pin vector layout
`define PFS_PIN_W 33
`define PFS_ADDR_LSB 0
`define PFS_DATA_LSB 13
`define PFS_PF_LSB 21
`define PFS_SER_LSB 29

// Cycles after reset release before the strap pins are trusted
`define PFS_STRAP_SETTLE 3'h4

`endif

// [src/pfs_pkg.sv]
// Purpose: State types for the pin function select block.
// Assumes: Widths fixed by pfs_params.svh.
// Notes: Each module keeps all of its state in one of these structs.
`include "pfs_params.svh"

package pfs_pkg;

	// Synchroniser state, three stages plus the agreed value
	typedef struct packed {
		logic [`PFS_PIN_W-1:0] s1;
		logic [`PFS_PIN_W-1:0] s2;
		logic [`PFS_PIN_W-1:0] s3;
		logic [`PFS_PIN_W-1:0] stable;
	} pfs_sync_t;

	// Top-level state, registers and registered outputs
	typedef struct packed {
		logic avs_wait;
		logic [31:0] avs_rdata;
		logic ctrl_serial;
		logic [7:0] flag_dir;
		logic [7:0] flag_val;
		logic flag_output;
		logic [3:0] strap;
		logic [2:0] strap_cnt;
		logic strap_done;
		logic [13:0] addr_o;
		logic [13:0] addr_oe;
		logic [7:0] data_o;
		logic [7:0] data_oe;
		logic [7:0] pf_o;
		logic [7:0] pf_oe;
		logic [3:0] ser_o;
		logic [3:0] ser_oe;
		logic [7:0] core_data;
		logic [15:0] host_ad;
		logic [3:0] host_ctl_n;
		logic [3:0] pf_irq_n;
		logic [1:0] ser_irq_n;
		logic flag_in;
		logic ser_rx_data;
		logic ser_tx_sync;
		logic ser_rx_sync;
	} pfs_state_t;

endpackage

// [src/pfs_sync.sv]
// Purpose: Three-stage synchroniser for every pin input of the block.
// Assumes: One clock; pins are asynchronous to it.
// Notes: A bit changes only once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
`include "pfs_params.svh"

module pfs_sync (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic [`PFS_PIN_W-1:0] pins_in,
	output logic [`PFS_PIN_W-1:0] stable_out
);
	import pfs_pkg::*;

	pfs_sync_t st_q; // Registered state
	pfs_sync_t st_d; // Next state

	// Next state; first stage feeds only the second
	always_comb begin
		st_d = st_q;
		st_d.s1 = pins_in;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		// Take a bit only where stages two and three agree
		// Agreement at either level moves the bit; disagreement holds it
		st_d.stable = (st_q.s2 & ~(st_q.s2 ^ st_q.s3)) | (st_q.stable & (st_q.s2 ^ st_q.s3));
	end

	// State register, synchronous clear
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign stable_out = st_q.stable;

endmodule // pfs_sync
`default_nettype wire

// [src/pfs_top.sv]
// Purpose: Pin function select for shared bus, flag, interrupt and serial pins.
// Assumes: 200 MHz core_clk_in; pin inputs asynchronous; core signals on this clock.
// Notes: Every pin output and enable is registered, so pins follow one cycle late.
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pfs_params.svh"

module pfs_top (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	// Avalon-MM slave
	input wire logic [4:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Shared address pins A0..A13
	input wire logic [13:1] addr_pin_in,
	output logic [13:0] addr_pin_out,
	output logic [13:0] addr_pin_oe_out,
	// Shared data pins D0..D7
	input wire logic [7:0] data_pin_in,
	output logic [7:0] data_pin_out,
	output logic [7:0] data_pin_oe_out,
	// Programmable flag pins 0..7
	input wire logic [7:0] programmable_flag_in,
	output logic [7:0] programmable_flag_out,
	output logic [7:0] programmable_flag_oe_out,
	// Serial port one pins: tx data, tx sync, rx sync, rx data
	input wire logic [3:0] serial_one_pin_in,
	output logic [3:0] serial_one_pin_out,
	output logic [3:0] serial_one_pin_oe_out,
	// Core external bus side
	input wire logic [13:0] core_addr_in,
	input wire logic [7:0] core_data_in,
	input wire logic core_data_oe_in,
	output logic [7:0] core_data_out,
	// Core host memory port side
	input wire logic [15:0] host_addr_data_in,
	input wire logic host_addr_data_oe_in,
	input wire logic host_acknowledge_n_in,
	output logic [15:0] host_addr_data_out,
	output logic host_chip_select_n_out,
	output logic host_address_latch_out,
	output logic host_read_strobe_n_out,
	output logic host_write_strobe_n_out,
	// Core interrupt inputs from flag pins 4..7
	output logic edge_interrupt_n_out,
	output logic level_interrupt_zero_n_out,
	output logic level_interrupt_one_n_out,
	output logic interrupt_two_n_out,
	// Core serial port one side
	input wire logic serial_one_tx_data_in,
	input wire logic serial_one_tx_sync_in,
	input wire logic serial_one_tx_sync_oe_in,
	input wire logic serial_one_rx_sync_in,
	input wire logic serial_one_rx_sync_oe_in,
	output logic serial_one_tx_sync_out,
	output logic serial_one_rx_sync_out,
	output logic serial_one_rx_data_out,
	output logic interrupt_one_n_out,
	output logic interrupt_zero_n_out,
	output logic flag_input_out
);
	import pfs_pkg::*;

	pfs_state_t st_q; // Registered state
	pfs_state_t st_d; // Next state
	logic [`PFS_PIN_W-1:0] pin_raw; // All asynchronous pin inputs
	logic [`PFS_PIN_W-1:0] pin_s; // Synchronised, agreed levels
	logic [12:0] ps_addr; // A1..A13 levels
	logic [7:0] ps_data; // D0..D7 levels
	logic [7:0] ps_pf; // Flag pin levels
	logic [3:0] ps_ser; // Serial pin levels
	logic bus_req; // Avalon request present
	logic mode_host; // Host port owns shared pins
	logic [31:0] rd_val; // Read mux result

	assign pin_raw = {serial_one_pin_in, programmable_flag_in, data_pin_in, addr_pin_in};

	// One synchroniser for all pins keeps the three-stage filter uniform
	pfs_sync u_sync (
		.core_clk_in(core_clk_in),
		.resetn_in(resetn_in),
		.pins_in(pin_raw),
		.stable_out(pin_s)
	);

	assign ps_addr = pin_s[`PFS_ADDR_LSB +: 13];
	assign ps_data = pin_s[`PFS_DATA_LSB +: 8];
	assign ps_pf = pin_s[`PFS_PF_LSB +: 8];
	assign ps_ser = pin_s[`PFS_SER_LSB +: 4];
	assign bus_req = avs_read_in | avs_write_in;
	assign mode_host = st_q.strap[`PFS_STRAP_MODE_C];

	// Register read mux; unmapped offsets read zero
	always_comb begin
		rd_val = 32'h0000_0000;
		case (avs_address_in)
			`PFS_OFS_SYS_CTRL: begin
				rd_val[`PFS_SYS_SERIAL_BIT] = st_q.ctrl_serial;
			end
			`PFS_OFS_FLAG_DIR: begin
				rd_val[7:0] = st_q.flag_dir;
			end
			`PFS_OFS_FLAG_VAL: begin
				rd_val[7:0] = st_q.flag_val;
			end
			`PFS_OFS_FLAG_OUT: begin
				rd_val[0] = st_q.flag_output;
			end
			`PFS_OFS_STATUS: begin
				rd_val[3:0] = st_q.strap;
				rd_val[`PFS_STAT_DONE_BIT] = st_q.strap_done;
				rd_val[`PFS_STAT_PF_LSB +: 8] = ps_pf;
				rd_val[`PFS_STAT_FLAG_IN_BIT] = ps_ser[3];
			end
			default: begin
				rd_val = 32'h0000_0000;
			end
		endcase
	end

	// Next state for bus, straps and every pin mux
	always_comb begin
		st_d = st_q;

		// Bus slave: one wait cycle, then done; writes land on the done edge
		if (bus_req && st_q.avs_wait) begin
			st_d.avs_wait = 1'b0;
			st_d.avs_rdata = avs_read_in ? rd_val : st_q.avs_rdata;
		end else if (!st_q.avs_wait) begin
			st_d.avs_wait = 1'b1;
			if (avs_write_in) begin
				case (avs_address_in)
					`PFS_OFS_SYS_CTRL: begin
						// Serial select lives in byte lane one
						if (avs_byteenable_in[1]) begin
							st_d.ctrl_serial = avs_writedata_in[`PFS_SYS_SERIAL_BIT];
						end
					end
					`PFS_OFS_FLAG_DIR: begin
						if (avs_byteenable_in[0]) begin
							st_d.flag_dir = avs_writedata_in[7:0];
						end
					end
					`PFS_OFS_FLAG_VAL: begin
						if (avs_byteenable_in[0]) begin
							st_d.flag_val = avs_writedata_in[7:0];
						end
					end
					`PFS_OFS_FLAG_OUT: begin
						if (avs_byteenable_in[0]) begin
							st_d.flag_output = avs_writedata_in[0];
						end
					end
					default: begin
						// Status and unmapped writes are ignored
						st_d.ctrl_serial = st_q.ctrl_serial;
					end
				endcase
			end
		end

		// Strap capture once the synchroniser holds post-release levels
		if (!st_q.strap_done) begin
			st_d.strap_cnt = st_q.strap_cnt + 3'h1;
			if (st_q.strap_cnt == `PFS_STRAP_SETTLE) begin
				st_d.strap = ps_pf[3:0];
				st_d.strap_done = 1'b1;
			end
		end

		// Shared bus pins; drivers stay off until the mode is known
		if (mode_host) begin
			// Host port owns A1..A13 and D0..D7
			st_d.addr_o = {host_addr_data_in[12:0], core_addr_in[0]};
			st_d.addr_oe = {{13{host_addr_data_oe_in}}, 1'b1};
			st_d.data_o = {4'h0, host_acknowledge_n_in, host_addr_data_in[15:13]};
			st_d.data_oe = {4'h0, 1'b1, {3{host_addr_data_oe_in}}};
			st_d.host_ad = {ps_data[2:0], ps_addr};
			st_d.host_ctl_n = ps_data[7:4];
			st_d.core_data = 8'h00;
		end else begin
			// Plain external address and data bus
			st_d.addr_o = core_addr_in;
			st_d.addr_oe = 14'h3FFF;
			st_d.data_o = core_data_in;
			st_d.data_oe = {8{core_data_oe_in}};
			st_d.host_ad = 16'h0000;
			st_d.host_ctl_n = 4'hF;
			st_d.core_data = ps_data;
		end
		if (!st_q.strap_done) begin
			st_d.addr_oe = 14'h0000;
			st_d.data_oe = 8'h00;
		end

		// Flag pins; the upper four also feed interrupts whatever the mode
		st_d.pf_o = st_q.flag_val;
		st_d.pf_oe = st_q.strap_done ? st_q.flag_dir : 8'h00;
		st_d.pf_irq_n = ps_pf[7:4];

		// Serial port one pins or interrupt and flag pins
		if (st_q.ctrl_serial) begin
			st_d.ser_o = {1'b0, serial_one_rx_sync_in, serial_one_tx_sync_in,
				serial_one_tx_data_in};
			st_d.ser_oe = {1'b0, serial_one_rx_sync_oe_in, serial_one_tx_sync_oe_in, 1'b1};
			st_d.ser_tx_sync = ps_ser[1];
			st_d.ser_rx_sync = ps_ser[2];
			st_d.ser_rx_data = ps_ser[3];
			st_d.ser_irq_n = 2'h3;
			st_d.flag_in = 1'b0;
		end else begin
			st_d.ser_o = {3'h0, st_q.flag_output};
			st_d.ser_oe = 4'h1;
			st_d.ser_tx_sync = 1'b0;
			st_d.ser_rx_sync = 1'b0;
			st_d.ser_rx_data = 1'b0;
			st_d.ser_irq_n = {ps_ser[1], ps_ser[2]};
			st_d.flag_in = ps_ser[3];
		end
	end

	// State register with synchronous reset to constants
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			st_q <= '0;
			st_q.avs_wait <= 1'b1;
			st_q.ctrl_serial <= `PFS_RST_SERIAL;
			st_q.flag_dir <= `PFS_RST_FLAG_DIR;
			st_q.flag_val <= `PFS_RST_FLAG_VAL;
			st_q.flag_output <= `PFS_RST_FLAG_OUT;
			st_q.host_ctl_n <= 4'hF;
			st_q.pf_irq_n <= 4'hF;
			st_q.ser_irq_n <= 2'h3;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state register
	assign avs_readdata_out = st_q.avs_rdata;
	assign avs_waitrequest_out = st_q.avs_wait;
	assign addr_pin_out = st_q.addr_o;
	assign addr_pin_oe_out = st_q.addr_oe;
	assign data_pin_out = st_q.data_o;
	assign data_pin_oe_out = st_q.data_oe;
	assign programmable_flag_out = st_q.pf_o;
	assign programmable_flag_oe_out = st_q.pf_oe;
	assign serial_one_pin_out = st_q.ser_o;
	assign serial_one_pin_oe_out = st_q.ser_oe;
	assign core_data_out = st_q.core_data;
	assign host_addr_data_out = st_q.host_ad;
	assign host_chip_select_n_out = st_q.host_ctl_n[0];
	assign host_address_latch_out = st_q.host_ctl_n[1];
	assign host_read_strobe_n_out = st_q.host_ctl_n[2];
	assign host_write_strobe_n_out = st_q.host_ctl_n[3];
	assign edge_interrupt_n_out = st_q.pf_irq_n[0];
	assign level_interrupt_zero_n_out = st_q.pf_irq_n[1];
	assign level_interrupt_one_n_out = st_q.pf_irq_n[2];
	assign interrupt_two_n_out = st_q.pf_irq_n[3];
	assign serial_one_tx_sync_out = st_q.ser_tx_sync;
	assign serial_one_rx_sync_out = st_q.ser_rx_sync;
	assign serial_one_rx_data_out = st_q.ser_rx_data;
	assign interrupt_one_n_out = st_q.ser_irq_n[1];
	assign interrupt_zero_n_out = st_q.ser_irq_n[0];
	assign flag_input_out = st_q.flag_in;

	// Checks on the mux and strap behaviour
	sequence s_release;
		!resetn_in ##1 resetn_in [*6];
	endsequence

	property p_host_bus;
		@(posedge core_clk_in) disable iff (!resetn_in)
		(st_q.strap_done && mode_host) |=> (host_addr_data_out == $past({ps_data[2:0], ps_addr}));
	endproperty
	a_host_bus: assert property (p_host_bus) else $error("host bus not routed");

	property p_plain_bus;
		@(posedge core_clk_in) disable iff (!resetn_in)
		(st_q.strap_done && !mode_host) |=> (addr_pin_oe_out == 14'h3FFF &&
			addr_pin_out == $past(core_addr_in) && host_chip_select_n_out);
	endproperty
	a_plain_bus: assert property (p_plain_bus) else $error("plain bus not routed");

	property p_pf_irq;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_q.strap_done |=> ({interrupt_two_n_out, level_interrupt_one_n_out,
			level_interrupt_zero_n_out, edge_interrupt_n_out} == $past(ps_pf[7:4]));
	endproperty
	a_pf_irq: assert property (p_pf_irq) else $error("flag interrupt lost");

	property p_strap_cap;
		@(posedge core_clk_in)
		s_release |-> (st_q.strap_done && st_q.strap == $past(ps_pf[3:0]));
	endproperty
	a_strap_cap: assert property (p_strap_cap) else $error("strap not captured");

	property p_serial_on;
		@(posedge core_clk_in) disable iff (!resetn_in)
		(resetn_in && st_q.ctrl_serial) |=> (serial_one_pin_out[0] == $past(serial_one_tx_data_in) &&
			serial_one_pin_oe_out[0] && serial_one_rx_data_out == $past(ps_ser[3]));
	endproperty
	a_serial_on: assert property (p_serial_on) else $error("serial pins wrong");

	property p_serial_off;
		@(posedge core_clk_in) disable iff (!resetn_in)
		!st_q.ctrl_serial |=> (serial_one_pin_out[0] == $past(st_q.flag_output) &&
			interrupt_one_n_out == $past(ps_ser[1]) && flag_input_out == $past(ps_ser[3]));
	endproperty
	a_serial_off: assert property (p_serial_off) else $error("flag pins wrong");

	property p_serial_rst;
		@(posedge core_clk_in)
		!resetn_in |=> st_q.ctrl_serial;
	endproperty
	a_serial_rst: assert property (p_serial_rst) else $error("serial bit not set");

	property p_strap_hold;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_q.strap_done |=> (st_q.strap_done && $stable(st_q.strap));
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

endmodule // pfs_top
`default_nettype wire
